/* File: dual_dac_serial_loader.sv */
// Serial loader of a two-channel 16-bit converter, with AHB-Lite read-back.
// Assumes hclk at 250 MHz and a serial clock much slower, sampled here.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "dual_dac_loader_consts.svh"

module dual_dac_serial_loader (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        frame_sync_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  output logic      [15:0] channel_a_output,
  output logic      [15:0] channel_b_output,
  output logic      [1:0]  channel_a_power,
  output logic      [1:0]  channel_b_power,
  output logic             channel_a_hiz,
  output logic             channel_b_hiz
);

  typedef struct packed {
    logic [1:0]  sync_n;
    logic [2:0]  sclk;
    logic [1:0]  sdata;
    logic [23:0] shift;
    logic [4:0]  count;
    dual_dac_loader_pkg::chan_t buf_a;
    dual_dac_loader_pkg::chan_t buf_b;
    dual_dac_loader_pkg::chan_t reg_a;
    dual_dac_loader_pkg::chan_t reg_b;
    logic        done;
    logic [15:0] words;
    logic        hiz_a;
    logic        hiz_b;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [31:0] chan_word(input dual_dac_loader_pkg::chan_t c);
    chan_word = {14'h0000, c.power, c.code};
  endfunction

  logic        fall;
  logic [23:0] word;
  logic        sel_b;
  logic        rd_take;
  dual_dac_loader_pkg::chan_t incoming;

  always_comb begin
    s_d = s_q;
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    s_d.sync_n = {s_q.sync_n[0], frame_sync_n};
    s_d.sclk   = {s_q.sclk[1:0], serial_clk};
    s_d.sdata  = {s_q.sdata[0], serial_data};
    s_d.done   = 1'b0;
    fall     = s_q.sclk[2] & ~s_q.sclk[1];
    word     = {s_q.shift[22:0], s_q.sdata[1]};
    sel_b    = word[`BUF_SEL_BIT];
    incoming.power = word[`PWR_HI_BIT:`PWR_LO_BIT];
    incoming.code  = (incoming.power == `PWR_NORMAL) ? word[`DATA_MSB:0] : `CODE_RESET;
    // ****************************************************************
    // Serial word capture
    // ****************************************************************
    if (s_q.sync_n[1]) begin
      s_d.shift = 24'h000000;
      s_d.count = 5'd0;
    end else if (fall) begin
      s_d.shift = word;
      s_d.count = s_q.count + 5'd1;
      if (s_q.count == `FRAME_COUNT_LAST) begin
        s_d.done  = 1'b1;
        s_d.words = s_q.words + 16'h0001;
        s_d.count = 5'd0;
        if (sel_b) s_d.buf_b = incoming;
        else       s_d.buf_a = incoming;
        if (word[`LOAD_A_BIT]) s_d.reg_a = s_d.buf_a;
        if (word[`LOAD_B_BIT]) s_d.reg_b = s_d.buf_b;
      end
    end
    s_d.hiz_a = (s_d.reg_a.power == dual_dac_loader_pkg::PWR_HIZ);
    s_d.hiz_b = (s_d.reg_b.power == dual_dac_loader_pkg::PWR_HIZ);
    // ****************************************************************
    // Bus slave, reads only, zero wait
    // ****************************************************************
    // Read data is taken in the address phase so it stands in the data phase.
    rd_take = hsel & hready & htrans[1] & ~hwrite;
    unique case (haddr[4:0])
      5'(`ADDR_CHAN_A): s_d.rdata = chan_word(s_q.reg_a);
      5'(`ADDR_CHAN_B): s_d.rdata = chan_word(s_q.reg_b);
      5'(`ADDR_BUF_A):  s_d.rdata = chan_word(s_q.buf_a);
      5'(`ADDR_BUF_B):  s_d.rdata = chan_word(s_q.buf_b);
      `ADDR_STATUS:     s_d.rdata = {11'h000, s_q.count, s_q.words};
      default:          s_d.rdata = 32'h00000000;
    endcase
    if (!rd_take || (haddr[31:5] != 27'h0000000)) s_d.rdata = 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.sync_n <= 2'h3;
      s_q.sclk   <= 3'h7;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata           = s_q.rdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign channel_a_output = s_q.reg_a.code;
  assign channel_b_output = s_q.reg_b.code;
  assign channel_a_power  = s_q.reg_a.power;
  assign channel_b_power  = s_q.reg_b.power;
  assign channel_a_hiz    = s_q.hiz_a;
  assign channel_b_hiz    = s_q.hiz_b;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_only_on_done;
    @(posedge hclk) disable iff (!hresetn)
      !s_d.done |=> $stable(s_q.reg_a) && $stable(s_q.reg_b);
  endproperty
  a_only_on_done: assert property (p_only_on_done)
    else $error("channel changed without load");

  property p_abort;
    @(posedge hclk) disable iff (!hresetn)
      s_q.sync_n[1] |=> s_q.count == 5'd0 && $stable(s_q.buf_a) && $stable(s_q.buf_b);
  endproperty
  a_abort: assert property (p_abort)
    else $error("partial word took effect");

  property p_done_count;
    @(posedge hclk) disable iff (!hresetn)
      s_d.done |-> s_q.count == `FRAME_COUNT_LAST && fall;
  endproperty
  a_done_count: assert property (p_done_count)
    else $error("completion at wrong edge");

  property p_hiz;
    @(posedge hclk) disable iff (!hresetn)
      channel_a_hiz == (channel_a_power == 2'h3);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("channel a hiz mismatch");

  property p_hiz_b;
    @(posedge hclk) disable iff (!hresetn)
      channel_b_hiz == (channel_b_power == 2'h3);
  endproperty
  a_hiz_b: assert property (p_hiz_b)
    else $error("channel b hiz mismatch");

  property p_keep_a;
    @(posedge hclk) disable iff (!hresetn)
      s_d.done && !word[`LOAD_A_BIT] |=> $stable(s_q.reg_a);
  endproperty
  a_keep_a: assert property (p_keep_a)
    else $error("channel a changed without its load");

  property p_keep_b;
    @(posedge hclk) disable iff (!hresetn)
      s_d.done && !word[`LOAD_B_BIT] |=> $stable(s_q.reg_b);
  endproperty
  a_keep_b: assert property (p_keep_b)
    else $error("channel b changed without its load");

  property p_load_both;
    @(posedge hclk) disable iff (!hresetn)
      s_d.done && word[`LOAD_A_BIT] && word[`LOAD_B_BIT] |=>
        s_q.reg_a == s_q.buf_a && s_q.reg_b == s_q.buf_b;
  endproperty
  a_load_both: assert property (p_load_both)
    else $error("simultaneous load missed a channel");

endmodule // dual_dac_serial_loader

/* File: dual_dac_loader_consts.svh */
// Constants of the two-channel serial converter loader.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DUAL_DAC_LOADER_CONSTS_SVH
`define DUAL_DAC_LOADER_CONSTS_SVH

// ****************************************************************
// Serial word layout
// ****************************************************************
`define WORD_BITS        24
`define FRAME_COUNT_LAST 5'd23
`define LOAD_B_BIT       21
`define LOAD_A_BIT       20
`define BUF_SEL_BIT      18
`define PWR_HI_BIT       17
`define PWR_LO_BIT       16
`define DATA_MSB         15

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_CHAN_A      4'h0
`define ADDR_CHAN_B      4'h4
`define ADDR_BUF_A       4'h8
`define ADDR_BUF_B       4'hc
`define ADDR_STATUS      5'h10
`define CODE_RESET       16'h0000
`define PWR_NORMAL       2'h0

`endif

/* File: dual_dac_loader_pkg.sv */
// Types of the two-channel serial converter loader.
// Assumes the constants header is on the include path.
package dual_dac_loader_pkg;
  `include "dual_dac_loader_consts.svh"

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_1K,
    PWR_100K,
    PWR_HIZ
  } power_mode_t;

  typedef struct packed {
    logic [15:0] code;
    logic [1:0]  power;
  } chan_t;
endpackage

/* File: serial_host_model.sv */
// Host model that sends serial frames into the converter loader.
// Assumes hclk runs; the serial clock idles high and stands still between frames.
`timescale 1ns/10ps
module serial_host_model (
  input  wire logic hclk,
  output logic      frame_sync_n,
  output logic      serial_clk,
  output logic      serial_data
);
  initial begin
    frame_sync_n = 1'b1;
    serial_clk   = 1'b1;
    serial_data  = 1'b0;
  end

  // ****
  // Frame sender
  // ****
  // sends the top n bits of w, msb first.
  task automatic send(input logic [23:0] w, input int n);
    @(posedge hclk) frame_sync_n <= 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      serial_data <= w[i];
      repeat (8) @(posedge hclk);
      serial_clk <= 1'b0;
      repeat (8) @(posedge hclk);
      serial_clk <= 1'b1;
    end
    repeat (8) @(posedge hclk);
    frame_sync_n <= 1'b1;
    serial_data  <= ~serial_data;
    repeat (8) @(posedge hclk);
  endtask
endmodule // serial_host_model

/* File: test_dual_dac_serial_loader.sv */
// Self-checking bench of the two-channel serial converter loader.
// Assumes the host model is compiled first; the bus is read-only.
`timescale 1ns/10ps
module test_dual_dac_serial_loader;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, fs_n, sck, sdo, a_hiz, b_hiz;
  logic [15:0] a_code, b_code;
  logic [1:0]  a_pwr, b_pwr;
  int          n_fail = 0;
  int          n_checks = 0;

  always #2 hclk = ~hclk;

  serial_host_model i_host (.hclk(hclk), .frame_sync_n(fs_n), .serial_clk(sck),
    .serial_data(sdo));

  dual_dac_serial_loader i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .frame_sync_n(fs_n),
    .serial_clk(sck), .serial_data(sdo), .channel_a_output(a_code),
    .channel_b_output(b_code), .channel_a_power(a_pwr), .channel_b_power(b_pwr),
    .channel_a_hiz(a_hiz), .channel_b_hiz(b_hiz));

  // ****
  // Tasks
  // ****
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task wait_ready;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_fail++;
        give_verdict;
      end
      @(posedge hclk);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] e);
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= a;
    htrans <= 2'h2;
    wait_ready;
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= 32'hffff_ffff;
    wait_ready;
    if (!w)
      check(hrdata, e);
  endtask

  task chan(input logic [31:0] ea, input logic [31:0] eb);
    check({13'h0, a_hiz, a_pwr, a_code}, ea);
    check({13'h0, b_hiz, b_pwr, b_code}, eb);
    bus(1'b0, 32'h0, ea & 32'h3ffff);
    bus(1'b0, 32'h4, eb & 32'h3ffff);
  endtask

  // ****
  // Tests
  // ****
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b0, 32'h20, 32'h0);
    bus(1'b0, 32'hc, 32'h0);
    chan(32'h0, 32'h0);
    $display("reset test done");
    i_host.send(24'h00_1234, 24);
    bus(1'b0, 32'h8, 32'h1234);
    chan(32'h0, 32'h0);
    i_host.send(24'h34_5678, 24);
    chan(32'h1234, 32'h5678);
    i_host.send(24'h18_aaaa, 24);
    chan(32'haaaa, 32'h5678);
    i_host.send(24'h24_bbbb, 24);
    chan(32'haaaa, 32'hbbbb);
    $display("load test done");
    i_host.send(24'h01_ffff, 24);
    bus(1'b0, 32'h8, 32'h1_0000);
    chan(32'haaaa, 32'hbbbb);
    i_host.send(24'h36_0000, 24);
    chan(32'h1_0000, 32'h2_0000);
    i_host.send(24'h13_0000, 24);
    chan(32'h7_0000, 32'h2_0000);
    i_host.send(24'h27_0000, 24);
    chan(32'h7_0000, 32'h7_0000);
    $display("power test done");
    i_host.send(24'h34_9999, 23);
    chan(32'h7_0000, 32'h7_0000);
    i_host.send(24'h10_4321, 24);
    chan(32'h4321, 32'h7_0000);
    $display("abort test done");
    bus(1'b0, 32'h10, 32'h9);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chan(32'h0, 32'h0);
    bus(1'b0, 32'hc, 32'h0);
    bus(1'b0, 32'h10, 32'h0);
    $display("status and reset test done");
    give_verdict;
  end
endmodule // test_dual_dac_serial_loader
